// ===== rtl/twslv_pkg.sv
/*
  shared constants, types and register map of the two-wire slave receiver.
  assumes a 32-bit apb master and an external open-drain bus resolver.
*/
package twslv_pkg;

  // ****************************************
  // register map and fields
  // ****************************************
  localparam int             ADDR_W       = 12;
  localparam logic [11:0]    OFF_OWN      = 12'h000;
  localparam logic [11:0]    OFF_CTRL     = 12'h004;
  localparam logic [11:0]    OFF_STAT     = 12'h008;
  localparam logic [11:0]    OFF_DATA     = 12'h00C;
  localparam int             CB_FLAG      = 7;
  localparam int             CB_ACK       = 6;
  localparam int             CB_STA       = 5;
  localparam int             CB_STO       = 4;
  localparam int             CB_WC        = 3;
  localparam int             CB_EN        = 2;
  localparam int             CB_IE        = 0;
  localparam int             OB_GCE       = 0;
  localparam logic [7:0]     RST_BYTE     = 8'h00;
  localparam logic [6:0]     GC_ADDR      = 7'h00;
  localparam logic [3:0]     BYTE_BITS    = 4'h8;

  // ****************************************
  // status codes, prescaler bits read zero
  // ****************************************
  localparam logic [7:0]     ST_OWN       = 8'h60;
  localparam logic [7:0]     ST_ARB_OWN   = 8'h68;
  localparam logic [7:0]     ST_GC        = 8'h70;
  localparam logic [7:0]     ST_ARB_GC    = 8'h78;
  localparam logic [7:0]     ST_D_ACK     = 8'h80;
  localparam logic [7:0]     ST_D_NACK    = 8'h88;
  localparam logic [7:0]     ST_GD_ACK    = 8'h90;
  localparam logic [7:0]     ST_GD_NACK   = 8'h98;
  localparam logic [7:0]     ST_NONE      = 8'hF8;

  typedef enum logic [2:0] {
    S_IDLE     = 3'b000,
    S_ADDR     = 3'b001,
    S_ADDR_ACK = 3'b011,
    S_WAIT     = 3'b010,
    S_DATA     = 3'b110,
    S_DATA_ACK = 3'b111
  } twslv_state_t;

  typedef struct packed {
    logic              psel;
    logic              penable;
    logic              pwrite;
    logic [11:0]       paddr;
    logic [31:0]       pwdata;
  } twslv_apb_req_t;

  typedef struct packed {
    logic              pready;
    logic [31:0]       prdata;
    logic              pslverr;
  } twslv_apb_rsp_t;

  typedef struct packed {
    logic              scl_o;
    logic              scl_oe;
    logic              sda_o;
    logic              sda_oe;
  } twslv_pin_t;

endpackage

// ===== rtl/twslv_top.sv
/*
  two-wire slave receiver with apb register slave.
  assumes scl and sda are resolved outside from the enables (low when any
  enable is high) and that the bus clock is far slower than pclk.
*/
// The register addresses and the APB slave port were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none

// Summary of operation
// - answer own seven-bit address from upper bits
// - low bit enables general call answer
// - write direction selects receive, read leaves
// - own write address sets flag and status
// - arbitration loss then addressed gives 0x68/0x78
// - ack enable cleared gives nack next byte
// - ack enable zero: no address ack
// - setting ack enable resumes recognition anytime
// - in sleep still match address via bus
// - sleep match wakes, holds clock until cleared
// - data register may miss byte in sleep
// - own address acked reports 0x60
// - general call acked reports 0x70
// - after clear receive next byte, ack per enable
// - acked own-address data byte reports 0x80
// - nacked own-address data byte reports 0x88
// - after 0x88 clear, back to unaddressed
module twslv_top (
  // clock and reset
  input  wire logic                      pclk,
  input  wire logic                      presetn,
  // apb slave
  input  wire twslv_pkg::twslv_apb_req_t apb_req,
  output var  twslv_pkg::twslv_apb_rsp_t apb_rsp,
  // two-wire bus pins
  input  wire logic                      scl_i,
  input  wire logic                      sda_i,
  output var  twslv_pkg::twslv_pin_t     pins,
  // master part and power manager
  input  wire logic                      arb_lost,
  input  wire logic                      sleep_mode,
  output logic                           wake_req
);
  import twslv_pkg::*;

  // ****************************************
  // pin synchronisers and bus events
  // ****************************************
  logic [2:0] scl_sync_q;
  logic [2:0] sda_sync_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scl_sync_q <= 3'h7;
      sda_sync_q <= 3'h7;
    end else begin
      scl_sync_q <= {scl_sync_q[1:0], scl_i};
      sda_sync_q <= {sda_sync_q[1:0], sda_i};
    end
  end

  logic scl_rise;
  logic scl_fall;
  logic bus_start;
  logic bus_stop;
  assign scl_rise  = scl_sync_q[1] & ~scl_sync_q[2];
  assign scl_fall  = ~scl_sync_q[1] & scl_sync_q[2];
  assign bus_start = scl_sync_q[1] & scl_sync_q[2] & ~sda_sync_q[1] & sda_sync_q[2];
  assign bus_stop  = scl_sync_q[1] & scl_sync_q[2] & sda_sync_q[1] & ~sda_sync_q[2];

  // ****************************************
  // apb slave, one wait state
  // ****************************************
  function automatic logic [2:0] reg_sel(input logic [11:0] a);
    if (a == OFF_OWN) begin
      reg_sel = 3'h4;
    end else if (a == OFF_CTRL) begin
      reg_sel = 3'h5;
    end else if (a == OFF_STAT) begin
      reg_sel = 3'h6;
    end else if (a == OFF_DATA) begin
      reg_sel = 3'h7;
    end else begin
      reg_sel = 3'h0;
    end
  endfunction

  logic         pready_q;
  logic [31:0]  prdata_q;
  logic         pslverr_q;
  logic [7:0]   own_address_reg_q;
  logic         ack_enable_q;
  logic         start_request_q;
  logic         stop_request_q;
  logic         interface_enable_q;
  logic         interrupt_enable_q;
  logic         service_flag_q;
  logic         write_collision_flag_q;
  logic [7:0]   status_reg_q;
  logic [7:0]   data_reg_q;
  logic         bus_wr;
  logic [2:0]   wsel;
  logic [7:0]   ctrl_rd;

  assign bus_wr  = apb_req.psel & apb_req.penable & pready_q & apb_req.pwrite;
  assign wsel    = reg_sel(apb_req.paddr);
  assign ctrl_rd = {service_flag_q, ack_enable_q, start_request_q, stop_request_q,
                    write_collision_flag_q, interface_enable_q, 1'b0, interrupt_enable_q};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q  <= 1'b0;
      prdata_q  <= 32'h0000_0000;
      pslverr_q <= 1'b0;
    end else begin
      pready_q  <= apb_req.psel & apb_req.penable & ~pready_q;
      pslverr_q <= apb_req.psel & apb_req.penable & ~pready_q & ~wsel[2];
      prdata_q  <= 32'h0000_0000;
      if (apb_req.psel & apb_req.penable & ~pready_q & ~apb_req.pwrite) begin
        case (wsel)
          3'h4: prdata_q <= {24'h00_0000, own_address_reg_q};
          3'h5: prdata_q <= {24'h00_0000, ctrl_rd};
          // prescaler bits kept at zero so codes compare directly
          3'h6: prdata_q <= {24'h00_0000, status_reg_q};
          3'h7: prdata_q <= {24'h00_0000, data_reg_q};
          default: prdata_q <= 32'h0000_0000;
        endcase
      end
    end
  end

  // ****************************************
  // configuration registers
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      own_address_reg_q  <= RST_BYTE;
      ack_enable_q       <= 1'b0;
      start_request_q    <= 1'b0;
      stop_request_q     <= 1'b0;
      interface_enable_q <= 1'b0;
      interrupt_enable_q <= 1'b0;
    end else if (bus_wr) begin
      if (wsel == 3'h4) begin
        own_address_reg_q <= apb_req.pwdata[7:0];
      end else if (wsel == 3'h5) begin
        // software sets enable and ack, clears start and stop
        ack_enable_q       <= apb_req.pwdata[CB_ACK];
        start_request_q    <= apb_req.pwdata[CB_STA];
        stop_request_q     <= apb_req.pwdata[CB_STO];
        interface_enable_q <= apb_req.pwdata[CB_EN];
        interrupt_enable_q <= apb_req.pwdata[CB_IE];
      end
    end
  end

  logic svc_clr;
  logic data_wr;
  assign svc_clr = bus_wr & (wsel == 3'h5) & apb_req.pwdata[CB_FLAG];
  assign data_wr = bus_wr & (wsel == 3'h7);

  // ****************************************
  // address match
  // ****************************************
  logic [7:0] shift_q;
  logic       is_own;
  logic       is_gc;
  logic       addr_hit;
  // write direction only; a read request belongs to the transmit side
  assign is_own   = (shift_q[7:1] == own_address_reg_q[7:1]) & ~shift_q[0];
  assign is_gc    = (shift_q[7:1] == GC_ADDR) & ~shift_q[0] & own_address_reg_q[OB_GCE];
  // ack enable is read live, so recognition returns the moment it is set
  assign addr_hit = (is_own | is_gc) & ack_enable_q;

  // ****************************************
  // receive state machine
  // ****************************************
  twslv_state_t state_q;
  logic [3:0]   bits_q;
  logic         ack_q;
  logic         gc_q;
  logic         arb_q;
  logic         sda_oe_q;
  logic         scl_oe_q;
  logic         wake_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      arb_q <= 1'b0;
    end else if (arb_lost) begin
      arb_q <= 1'b1;
    end else if (bus_stop | (state_q == S_WAIT)) begin
      arb_q <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q  <= S_IDLE;
      bits_q   <= 4'h0;
      shift_q  <= RST_BYTE;
      ack_q    <= 1'b0;
      gc_q     <= 1'b0;
      sda_oe_q <= 1'b0;
      scl_oe_q <= 1'b0;
    end else if (!interface_enable_q) begin
      state_q  <= S_IDLE;
      sda_oe_q <= 1'b0;
      scl_oe_q <= 1'b0;
    end else if (state_q == S_WAIT) begin
      if (svc_clr) begin
        scl_oe_q <= 1'b0;
        bits_q   <= 4'h0;
        // after a nack the slave drops out of the transfer
        // the stop bit of the clearing write itself decides, not the stored one
        if (!ack_q || apb_req.pwdata[CB_STO]) begin
          state_q <= S_IDLE;
        end else begin
          state_q <= S_DATA;
        end
      end
    end else if (bus_start) begin
      state_q  <= S_ADDR;
      bits_q   <= 4'h0;
      sda_oe_q <= 1'b0;
    end else if (bus_stop) begin
      state_q  <= S_IDLE;
      sda_oe_q <= 1'b0;
    end else begin
      if (scl_rise && (state_q == S_ADDR || state_q == S_DATA) && bits_q != BYTE_BITS) begin
        shift_q <= {shift_q[6:0], sda_sync_q[1]};
        bits_q  <= bits_q + 4'h1;
      end
      if (scl_fall) begin
        case (state_q)
          S_ADDR: begin
            if (bits_q == BYTE_BITS) begin
              // match runs in sleep too, off the bus clock edges
              if (addr_hit) begin
                state_q  <= S_ADDR_ACK;
                sda_oe_q <= 1'b1;
                gc_q     <= ~is_own;
                ack_q    <= 1'b1;
              end else begin
                state_q <= S_IDLE;
              end
            end
          end
          S_DATA: begin
            if (bits_q == BYTE_BITS) begin
              state_q  <= S_DATA_ACK;
              sda_oe_q <= ack_enable_q;
              ack_q    <= ack_enable_q;
            end
          end
          S_ADDR_ACK, S_DATA_ACK: begin
            state_q  <= S_WAIT;
            sda_oe_q <= 1'b0;
            scl_oe_q <= 1'b1;
          end
          default: state_q <= state_q;
        endcase
      end
    end
  end

  // ****************************************
  // service flag, status and data
  // ****************************************
  logic flag_set;
  assign flag_set = interface_enable_q & scl_fall & ~bus_start & ~bus_stop &
                    (state_q == S_ADDR_ACK || state_q == S_DATA_ACK);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      service_flag_q <= 1'b0;
      status_reg_q   <= ST_NONE;
    end else if (flag_set) begin
      // set beats a clear in the same cycle
      service_flag_q <= 1'b1;
      if (state_q == S_ADDR_ACK) begin
        if (gc_q) begin
          status_reg_q <= arb_q ? ST_ARB_GC : ST_GC;
        end else begin
          status_reg_q <= arb_q ? ST_ARB_OWN : ST_OWN;
        end
      end else if (gc_q) begin
        status_reg_q <= ack_q ? ST_GD_ACK : ST_GD_NACK;
      end else begin
        status_reg_q <= ack_q ? ST_D_ACK : ST_D_NACK;
      end
    end else if (svc_clr) begin
      service_flag_q <= 1'b0;
      status_reg_q   <= ST_NONE;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      data_reg_q             <= RST_BYTE;
      write_collision_flag_q <= 1'b0;
    end else if (flag_set && state_q == S_DATA_ACK && !sleep_mode) begin
      // a byte caught while asleep is not kept
      data_reg_q <= shift_q;
    end else if (data_wr) begin
      write_collision_flag_q <= ~service_flag_q;
      if (service_flag_q) begin
        data_reg_q <= apb_req.pwdata[7:0];
      end
    end
  end

  // long start-up keeps scl low the whole time; nothing here bounds it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wake_q <= 1'b0;
    end else if (flag_set && state_q == S_ADDR_ACK && sleep_mode) begin
      wake_q <= 1'b1;
    end else if (svc_clr) begin
      wake_q <= 1'b0;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign apb_rsp.pready  = pready_q;
  assign apb_rsp.prdata  = prdata_q;
  assign apb_rsp.pslverr = pslverr_q;
  assign pins.scl_o      = 1'b0;
  assign pins.sda_o      = 1'b0;
  assign pins.scl_oe     = scl_oe_q;
  assign pins.sda_oe     = sda_oe_q;
  assign wake_req        = wake_q;

  // ****************************************
  // assertions
  // ****************************************
  a_flag_holds_scl: assert property (@(posedge pclk) disable iff (!presetn)
    service_flag_q && state_q == S_WAIT |-> scl_oe_q)
    else $error("clock line released while flag set");

  a_own_status: assert property (@(posedge pclk) disable iff (!presetn)
    flag_set && state_q == S_ADDR_ACK && !gc_q && !arb_q |=> status_reg_q == 8'h60 && service_flag_q)
    else $error("own address status wrong");

  a_gc_status: assert property (@(posedge pclk) disable iff (!presetn)
    flag_set && state_q == S_ADDR_ACK && gc_q && !arb_q |=> status_reg_q == 8'h70)
    else $error("general call status wrong");

  a_arb_status: assert property (@(posedge pclk) disable iff (!presetn)
    flag_set && state_q == S_ADDR_ACK && arb_q |=> status_reg_q == (gc_q ? 8'h78 : 8'h68))
    else $error("arbitration status wrong");

  a_addr_ack_gate: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(state_q == S_ADDR_ACK) |-> $past(ack_enable_q) && sda_oe_q)
    else $error("address acked without ack enable");

  a_data_ack_lvl: assert property (@(posedge pclk) disable iff (!presetn)
    state_q == S_DATA_ACK |-> sda_oe_q == ack_q)
    else $error("data ack level wrong");

  a_data_status: assert property (@(posedge pclk) disable iff (!presetn)
    flag_set && state_q == S_DATA_ACK && !gc_q |=> status_reg_q == ($past(ack_q) ? 8'h80 : 8'h88))
    else $error("data status wrong");

  a_nack_exit: assert property (@(posedge pclk) disable iff (!presetn)
    state_q == S_WAIT && status_reg_q == 8'h88 && svc_clr && interface_enable_q |=> state_q == S_IDLE)
    else $error("no return to unaddressed after nack");

  a_resume_data: assert property (@(posedge pclk) disable iff (!presetn)
    state_q == S_WAIT && ack_q && !apb_req.pwdata[CB_STO] && svc_clr && interface_enable_q
    |=> state_q == S_DATA && !scl_oe_q)
    else $error("next byte not started after clear");

  a_sleep_wake: assert property (@(posedge pclk) disable iff (!presetn)
    flag_set && state_q == S_ADDR_ACK && sleep_mode |=> wake_req && scl_oe_q)
    else $error("no wake after sleep match");

endmodule

`default_nettype wire

// ===== bench/twslv_master.sv
/*
  behavioural two-wire bus master transmitter for the slave receiver bench.
  assumes pull-ups on both lines, resolved by the bench from all enables.
*/
`timescale 1ns/10ps
`default_nettype none

module twslv_master (
  // clock
  input  wire logic pclk,
  // resolved bus lines and pull-down enables
  input  wire logic scl,
  input  wire logic sda,
  output logic      scl_low,
  output logic      sda_low
);

  initial begin
    scl_low = 1'b0;
    sda_low = 1'b0;
  end

  // ****************************************
  // bit level, 160 ns steps; a whole bit takes at least 520 ns
  // ****************************************
  task automatic hp();
    repeat (4) @(posedge pclk);
  endtask

  // clock stands low between bits; a stretching slave delays the rise
  task automatic bit_io(input logic b, output logic r);
    sda_low <= ~b;
    hp();
    scl_low <= 1'b0;
    @(posedge pclk);
    while (scl !== 1'b1) @(posedge pclk);
    hp();
    r = sda;
    scl_low <= 1'b1;
    hp();
  endtask

  // ****************************************
  // framing
  // ****************************************
  task automatic start();
    sda_low <= 1'b1;
    hp();
    scl_low <= 1'b1;
    hp();
  endtask

  task automatic stop();
    sda_low <= 1'b1;
    hp();
    scl_low <= 1'b0;
    @(posedge pclk);
    while (scl !== 1'b1) @(posedge pclk);
    hp();
    sda_low <= 1'b0;
    hp();
  endtask

  // msb first, then a released ninth bit read back as the acknowledge
  task automatic send_byte(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(b[i], r);
    end
    bit_io(1'b1, r);
    ack = ~r;
  endtask

endmodule

`default_nettype wire

// ===== bench/twslv_bench.sv
/*
  self-checking bench of the two-wire slave receiver.
  assumes the twslv_master model drives the far side of the bus.
*/
`timescale 1ns/10ps
`default_nettype none

module twslv_bench;
  import twslv_pkg::*;

  logic           pclk;
  logic           presetn;
  logic           arb_lost;
  logic           sleep_mode;
  logic           wake_req;
  logic           scl_low;
  logic           sda_low;
  logic           ack;
  wire logic      scl;
  wire logic      sda;
  twslv_apb_req_t req;
  twslv_apb_rsp_t rsp;
  twslv_pin_t     pins;
  int             miscompares;
  int             checks;

  // open-drain lines with pull-ups
  assign scl = ~(scl_low | pins.scl_oe);
  assign sda = ~(sda_low | pins.sda_oe);

  twslv_top dut (.pclk(pclk), .presetn(presetn), .apb_req(req), .apb_rsp(rsp),
    .scl_i(scl), .sda_i(sda), .pins(pins), .arb_lost(arb_lost),
    .sleep_mode(sleep_mode), .wake_req(wake_req));

  twslv_master mst (.pclk(pclk), .scl(scl), .sda(sda), .scl_low(scl_low),
    .sda_low(sda_low));

  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  // ****************************************
  // shared tasks
  // ****************************************
  task automatic finish_test();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    @(posedge pclk);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
    @(posedge pclk);
    req.penable <= 1'b1;
    @(posedge pclk);
    while (rsp.pready !== 1'b1) @(posedge pclk);
    r = rsp.prdata;
    e = rsp.pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
  endtask

  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 32'h0, r, e);
    chk(r, exp);
  endtask

  // flag set lands a few cycles after the ack clock falls
  task automatic settle();
    repeat (6) @(posedge pclk);
  endtask

  task automatic addr(input logic [7:0] b, input logic exp);
    mst.start();
    mst.send_byte(b, ack);
    chk(32'(ack), 32'(exp));
    settle();
    chk(32'(pins.scl_oe), 32'(exp));
  endtask

  task automatic data(input logic [7:0] b, input logic exp);
    mst.send_byte(b, ack);
    chk(32'(ack), 32'(exp));
    settle();
  endtask

  task automatic clr_stop();
    wr(OFF_CTRL, 32'hC4);
    mst.stop();
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_regs();
    logic [31:0] r;
    logic        e;
    rd_chk(OFF_OWN, 32'h0);
    rd_chk(OFF_CTRL, 32'h0);
    rd_chk(OFF_STAT, 32'(ST_NONE));
    rd_chk(OFF_DATA, 32'h0);
    apb(1'b0, 12'h010, 32'h0, r, e);
    chk(r, 32'h0);
    chk(32'(e), 32'h1);
    wr(OFF_OWN, 32'hB5);
    rd_chk(OFF_OWN, 32'hB5);
    wr(OFF_CTRL, 32'h44);
    rd_chk(OFF_CTRL, 32'h44);
  endtask

  task automatic t_own();
    addr(8'hB4, 1'b1);
    rd_chk(OFF_CTRL, 32'hC4);
    rd_chk(OFF_STAT, 32'(ST_OWN));
    wr(OFF_CTRL, 32'hC4);
    settle();
    chk(32'(pins.scl_oe), 32'h0);
    data(8'h3C, 1'b1);
    rd_chk(OFF_STAT, 32'(ST_D_ACK));
    rd_chk(OFF_DATA, 32'h3C);
    wr(OFF_CTRL, 32'h84);
    data(8'hA5, 1'b0);
    rd_chk(OFF_STAT, 32'(ST_D_NACK));
    wr(OFF_CTRL, 32'h84);
    rd_chk(OFF_STAT, 32'(ST_NONE));
    mst.stop();
    addr(8'hB4, 1'b0);
    mst.stop();
    wr(OFF_CTRL, 32'h44);
    addr(8'hB4, 1'b1);
    clr_stop();
  endtask

  task automatic t_gc();
    addr(8'h00, 1'b1);
    rd_chk(OFF_STAT, 32'(ST_GC));
    clr_stop();
    wr(OFF_OWN, 32'hB4);
    addr(8'h00, 1'b0);
    mst.stop();
    addr(8'hB5, 1'b0);
    mst.stop();
    wr(OFF_OWN, 32'hB5);
  endtask

  task automatic t_arb(input logic [7:0] b, input logic [7:0] st);
    @(posedge pclk);
    arb_lost <= 1'b1;
    @(posedge pclk);
    arb_lost <= 1'b0;
    addr(b, 1'b1);
    rd_chk(OFF_STAT, 32'(st));
    clr_stop();
  endtask

  task automatic t_sleep();
    @(posedge pclk);
    sleep_mode <= 1'b1;
    addr(8'hB4, 1'b1);
    chk(32'(wake_req), 32'h1);
    wr(OFF_CTRL, 32'hC4);
    settle();
    chk(32'(wake_req), 32'h0);
    chk(32'(pins.scl_oe), 32'h0);
    // byte taken while still asleep leaves the older byte in place
    data(8'h5A, 1'b1);
    rd_chk(OFF_DATA, 32'hA5);
    @(posedge pclk);
    sleep_mode <= 1'b0;
    clr_stop();
  endtask

  // ****************************************
  // main sequence and watchdog
  // ****************************************
  initial begin
    presetn = 1'b0;
    arb_lost = 1'b0;
    sleep_mode = 1'b0;
    req = '0;
    miscompares = 0;
    checks = 0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_own();
    t_gc();
    t_arb(8'hB4, ST_ARB_OWN);
    t_arb(8'h00, ST_ARB_GC);
    t_sleep();
    finish_test();
  end

  // whole run needs under ten thousand cycles
  initial begin
    #(60000 * 40);
    miscompares++;
    finish_test();
  end

endmodule

`default_nettype wire
